// ### core/orr_readout.v
/*
 * digital side of the optical receiver: settings, period timer, sample and
 * convert phases, result capture, ambient subtraction and result stream.
 * assumes adc_code is valid on the ref_clk cycle where a convert phase ends
 * and that all setting and timing inputs come from logic on ref_clk.
 */
// Operation
// - seven selectable feedback resistor values
// - six independent feedback capacitor enables
// - five second-stage gain values
// - ambient cancellation code, ten 1 uA steps
// - each sample window programmed independently
// - one shared 22-bit converter, sequential codes
// - four raw streams, once per period
// - two emitter minus ambient difference outputs
// - 16-bit 4 MHz counter wraps at period
`timescale 1ns/1ps
`include "orr_defs.vh"

module orr_readout #(
	parameter CNT_W = `ORR_CNT_W,
	parameter ADC_W = `ORR_ADC_W
) (
	// clock and reset
	input  wire                      ref_clk,
	input  wire                      reset_n,
	// power control
	input  wire                      hard_powerdown_pin_n,
	input  wire                      soft_powerdown_bit,
	// receiver settings
	input  wire [`ORR_RF_W-1:0]      rf_sel,
	input  wire [`ORR_CF_W-1:0]      cf_sel,
	input  wire [`ORR_GAIN_W-1:0]    gain_sel,
	input  wire [`ORR_AMB_W-1:0]     amb_cancel_sel,
	// period and phase timing, channel 0 in the low bits
	input  wire [CNT_W-1:0]          prp_value,
	input  wire [4*CNT_W-1:0]        samp_start,
	input  wire [4*CNT_W-1:0]        samp_end,
	input  wire [4*CNT_W-1:0]        conv_start,
	input  wire [4*CNT_W-1:0]        conv_end,
	// converter
	input  wire [ADC_W-1:0]          adc_code,
	// applied settings
	output reg  [`ORR_RF_W-1:0]      rf_code_q,
	output reg  [`ORR_CF_W-1:0]      cf_code_q,
	output reg  [`ORR_GAIN_W-1:0]    gain_code_q,
	output reg  [`ORR_AMB_W-1:0]     amb_code_q,
	output reg                       active_q,
	// analog phase controls
	output reg  [`ORR_NCH-1:0]       sample_phase_q,
	output reg  [`ORR_NCH-1:0]       convert_phase_q,
	output reg  [CNT_W-1:0]          timer_q,
	// held results
	output reg  [ADC_W-1:0]          res_emitter_b_q,
	output reg  [ADC_W-1:0]          res_amb_b_q,
	output reg  [ADC_W-1:0]          res_emitter_a_q,
	output reg  [ADC_W-1:0]          res_amb_a_q,
	output reg  [`ORR_DIFF_W-1:0]    res_diff_b_q,
	output reg  [`ORR_DIFF_W-1:0]    res_diff_a_q,
	output reg                       overrun_q,
	// result stream
	output wire                      out_valid,
	input  wire                      out_ready,
	output wire [`ORR_TAG_W-1:0]     out_tag,
	output wire [`ORR_DIFF_W-1:0]    out_data
);
	localparam FW = `ORR_TAG_W + `ORR_DIFF_W;

	// conversion sequencer, one-hot
	localparam [4:0] ST_EB   = 5'h01;
	localparam [4:0] ST_AB   = 5'h02;
	localparam [4:0] ST_EA   = 5'h04;
	localparam [4:0] ST_AA   = 5'h08;
	localparam [4:0] ST_DONE = 5'h10;

	reg                    pd_s1_q;
	reg                    pd_s2_q;
	reg [`ORR_ACC_W-1:0]   acc_q;
	reg [`ORR_ACC_W-1:0]   acc_d;
	reg                    tick;
	reg [4:0]              state_q;
	reg [4:0]              state_d;
	reg [1:0]              cur_ch;
	reg                    conv_done;
	reg                    raw_pend_q;
	reg [`ORR_TAG_W-1:0]   raw_tag_q;
	reg [ADC_W-1:0]        raw_data_q;
	reg                    diff_pend_q;
	reg [`ORR_TAG_W-1:0]   diff_tag_q;
	reg [`ORR_DIFF_W-1:0]  diff_data_q;
	reg                    fifo_in_valid;
	reg [FW-1:0]           fifo_in_data;
	wire                   fifo_in_ready;
	wire                   run;
	wire                   wrap;
	wire [`ORR_DIFF_W-1:0] diff_now;
	wire [FW-1:0]          fifo_out;
	wire [`ORR_NCH-1:0]    samp_hit;
	wire [`ORR_NCH-1:0]    conv_hit;
	wire [`ORR_NCH-1:0]    conv_last;

	// the pin is asynchronous to ref_clk
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			pd_s1_q <= 1'b0;
			pd_s2_q <= 1'b0;
		end else begin
			pd_s1_q <= hard_powerdown_pin_n;
			pd_s2_q <= pd_s1_q;
		end
	end

	assign run  = pd_s2_q & ~soft_powerdown_bit;
	assign wrap = tick & (timer_q == prp_value);

	// 4 MHz tick from 10 MHz: add 4 per cycle modulo 10, jitter of one cycle
	always @* begin
		tick  = 1'b0;
		acc_d = acc_q + `ORR_TIMER_CLK_MHZ;
		if (acc_d >= `ORR_REF_CLK_MHZ) begin
			tick  = 1'b1;
			acc_d = acc_d - `ORR_REF_CLK_MHZ;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < `ORR_NCH; ch = ch + 1) begin : g_phase
			// each channel compares against its own window pair
			assign samp_hit[ch]  = (timer_q >= samp_start[ch*CNT_W +: CNT_W]) &
				(timer_q <= samp_end[ch*CNT_W +: CNT_W]);
			assign conv_hit[ch]  = (timer_q >= conv_start[ch*CNT_W +: CNT_W]) &
				(timer_q <= conv_end[ch*CNT_W +: CNT_W]);
			assign conv_last[ch] = tick & (timer_q == conv_end[ch*CNT_W +: CNT_W]);
		end
	endgenerate

	// sequencer: one converter walks the channels in a fixed order per period
	always @* begin
		state_d   = state_q;
		cur_ch    = 2'h0;
		conv_done = 1'b0;
		case (state_q)
			ST_EB: begin
				cur_ch    = `ORR_CH_EB;
				conv_done = conv_last[`ORR_CH_EB];
				if (conv_done) state_d = ST_AB;
			end
			ST_AB: begin
				cur_ch    = `ORR_CH_AB;
				conv_done = conv_last[`ORR_CH_AB];
				if (conv_done) state_d = ST_EA;
			end
			ST_EA: begin
				cur_ch    = `ORR_CH_EA;
				conv_done = conv_last[`ORR_CH_EA];
				if (conv_done) state_d = ST_AA;
			end
			ST_AA: begin
				cur_ch    = `ORR_CH_AA;
				conv_done = conv_last[`ORR_CH_AA];
				if (conv_done) state_d = ST_DONE;
			end
			ST_DONE: begin
				state_d = ST_DONE;
			end
			default: begin
				state_d = ST_EB;
			end
		endcase
		if (wrap) state_d = ST_EB;
	end

	// difference against the emitter word just held for this pair
	assign diff_now = (cur_ch == `ORR_CH_AB) ?
		({res_emitter_b_q[ADC_W-1], res_emitter_b_q} - {adc_code[ADC_W-1], adc_code}) :
		({res_emitter_a_q[ADC_W-1], res_emitter_a_q} - {adc_code[ADC_W-1], adc_code});

	// settings: out-of-range codes are ignored and the last good one kept
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			rf_code_q   <= `ORR_RF_RST;
			cf_code_q   <= `ORR_CF_RST;
			gain_code_q <= `ORR_GAIN_RST;
			amb_code_q  <= `ORR_AMB_RST;
		end else begin
			if (rf_sel < `ORR_RF_COUNT) rf_code_q <= rf_sel;
			cf_code_q <= cf_sel;
			if (gain_sel < `ORR_GAIN_COUNT) gain_code_q <= gain_sel;
			if (amb_cancel_sel <= `ORR_AMB_MAX) amb_code_q <= amb_cancel_sel;
		end
	end

	// timer, phases and sequencer; power-down freezes the period at zero
	always @(posedge ref_clk) begin
		if (!reset_n || !run) begin
			acc_q           <= {`ORR_ACC_W{1'b0}};
			timer_q         <= {CNT_W{1'b0}};
			state_q         <= ST_EB;
			sample_phase_q  <= {`ORR_NCH{1'b0}};
			convert_phase_q <= {`ORR_NCH{1'b0}};
			active_q        <= 1'b0;
		end else begin
			active_q <= 1'b1;
			acc_q    <= acc_d;
			state_q  <= state_d;
			if (wrap) begin
				timer_q <= {CNT_W{1'b0}};
			end else if (tick) begin
				timer_q <= timer_q + 1'b1;
			end
			sample_phase_q  <= samp_hit;
			// only the sequencer's channel may drive the shared converter
			convert_phase_q <= conv_hit & (state_q[3:0]);
		end
	end

	// capture, hold and queue results
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			res_emitter_b_q <= {ADC_W{1'b0}};
			res_amb_b_q     <= {ADC_W{1'b0}};
			res_emitter_a_q <= {ADC_W{1'b0}};
			res_amb_a_q     <= {ADC_W{1'b0}};
			res_diff_b_q    <= {`ORR_DIFF_W{1'b0}};
			res_diff_a_q    <= {`ORR_DIFF_W{1'b0}};
			raw_pend_q      <= 1'b0;
			raw_tag_q       <= `ORR_TAG_EB;
			raw_data_q      <= {ADC_W{1'b0}};
			diff_pend_q     <= 1'b0;
			diff_tag_q      <= `ORR_TAG_DB;
			diff_data_q     <= {`ORR_DIFF_W{1'b0}};
			overrun_q       <= 1'b0;
		end else begin
			if (fifo_in_valid & fifo_in_ready) begin
				if (raw_pend_q) raw_pend_q <= 1'b0;
				else diff_pend_q <= 1'b0;
			end
			if (run & conv_done) begin
				// a raw word still waiting for the fifo is overwritten; any waiting word sets the flag
				if (raw_pend_q | diff_pend_q) overrun_q <= 1'b1;
				raw_pend_q <= 1'b1;
				raw_data_q <= adc_code;
				raw_tag_q  <= {1'b0, cur_ch};
				case (cur_ch)
					`ORR_CH_EB: res_emitter_b_q <= adc_code;
					`ORR_CH_AB: begin
						res_amb_b_q  <= adc_code;
						res_diff_b_q <= diff_now;
						diff_pend_q  <= 1'b1;
						diff_tag_q   <= `ORR_TAG_DB;
						diff_data_q  <= diff_now;
					end
					`ORR_CH_EA: res_emitter_a_q <= adc_code;
					default: begin
						res_amb_a_q  <= adc_code;
						res_diff_a_q <= diff_now;
						diff_pend_q  <= 1'b1;
						diff_tag_q   <= `ORR_TAG_DA;
						diff_data_q  <= diff_now;
					end
				endcase
			end
		end
	end

	// raw word goes first, its difference follows
	always @* begin
		fifo_in_valid = raw_pend_q | diff_pend_q;
		if (raw_pend_q) begin
			fifo_in_data = {raw_tag_q, raw_data_q[ADC_W-1], raw_data_q};
		end else begin
			fifo_in_data = {diff_tag_q, diff_data_q};
		end
	end

	orr_fifo #(
		.WIDTH (FW),
		.DEPTH (`ORR_FIFO_DEPTH),
		.AW    (`ORR_FIFO_AW)
	) u_fifo (
		.ref_clk     (ref_clk),
		.reset_n     (reset_n),
		.in_valid    (fifo_in_valid),
		.in_ready    (fifo_in_ready),
		.in_data     (fifo_in_data),
		.out_valid_q (out_valid),
		.out_ready   (out_ready),
		.out_data_q  (fifo_out)
	);

	assign out_tag  = fifo_out[FW-1 -: `ORR_TAG_W];
	assign out_data = fifo_out[`ORR_DIFF_W-1:0];
endmodule // orr_readout

// ### core/orr_defs.vh
/*
 * constants shared by the optical receiver readout and its result fifo.
 * assumes a single 10 MHz reference clock; no other file defines these names.
 */
`ifndef ORR_DEFS_VH
`define ORR_DEFS_VH

// clock rates in MHz, sized to the 4-bit fractional timer accumulator
`define ORR_REF_CLK_MHZ    4'hA
`define ORR_TIMER_CLK_MHZ  4'h4
`define ORR_ACC_W          4

// timer and converter widths
`define ORR_CNT_W          16
`define ORR_ADC_W          22
`define ORR_DIFF_W         23
`define ORR_TAG_W          3
`define ORR_NCH            4

// receiver setting code limits
`define ORR_RF_W           3
`define ORR_RF_COUNT       3'h7
`define ORR_CF_W           6
`define ORR_GAIN_W         3
`define ORR_GAIN_COUNT     3'h5
`define ORR_AMB_W          4
`define ORR_AMB_MAX        4'hA

// setting reset values
`define ORR_RF_RST         3'h0
`define ORR_CF_RST         6'h00
`define ORR_GAIN_RST       3'h0
`define ORR_AMB_RST        4'h0

// channel order within one period: emitter_b, its ambient, emitter_a, its ambient
`define ORR_CH_EB          2'h0
`define ORR_CH_AB          2'h1
`define ORR_CH_EA          2'h2
`define ORR_CH_AA          2'h3

// stream tags
`define ORR_TAG_EB         3'h0
`define ORR_TAG_AB         3'h1
`define ORR_TAG_EA         3'h2
`define ORR_TAG_AA         3'h3
`define ORR_TAG_DB         3'h4
`define ORR_TAG_DA         3'h5

// fifo geometry
`define ORR_FIFO_DEPTH     8
`define ORR_FIFO_AW        3

`endif

// ### core/orr_fifo.v
/*
 * result fifo with a registered output word, valid and ready on both sides.
 * assumes writer and reader share ref_clk; reset is synchronous, active low.
 */
`timescale 1ns/1ps
`include "orr_defs.vh"

module orr_fifo #(
	parameter WIDTH = 26,
	parameter DEPTH = `ORR_FIFO_DEPTH,
	parameter AW    = `ORR_FIFO_AW
) (
	// clock and reset
	input  wire             ref_clk,
	input  wire             reset_n,
	// fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// drain side
	output reg              out_valid_q,
	input  wire             out_ready,
	output reg  [WIDTH-1:0] out_data_q
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_q;
	reg [AW-1:0]    rd_ptr_q;
	reg [AW:0]      count_q;
	wire            push;
	wire            pop;
	wire            load;

	assign in_ready = (count_q != DEPTH[AW:0]);
	assign push     = in_valid & in_ready;
	// the output register refills whenever memory holds a word and it is empty or being taken
	assign load     = (count_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);
	assign pop      = load;

	always @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr_q] <= in_data;
		end
	end

	always @(posedge ref_clk) begin
		if (!reset_n) begin
			wr_ptr_q    <= {AW{1'b0}};
			rd_ptr_q    <= {AW{1'b0}};
			count_q     <= {(AW+1){1'b0}};
			out_valid_q <= 1'b0;
			out_data_q  <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			if (push & ~pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop & ~push) begin
				count_q <= count_q - 1'b1;
			end
			if (load) begin
				out_data_q  <= mem[rd_ptr_q];
				out_valid_q <= 1'b1;
			end else if (out_ready) begin
				out_valid_q <= 1'b0;
			end
		end
	end
endmodule // orr_fifo

// ### testbench/orr_readout_sva.sv
/* port assertions for the receiver readout, bound into orr_readout.
   assumes one clock ref_clk and a synchronous active-low reset_n. */
`timescale 1ns/1ps
`include "orr_defs.vh"
module orr_readout_sva #(
	parameter CNT_W = `ORR_CNT_W,
	parameter ADC_W = `ORR_ADC_W
) (
	// clock, reset, power
	input wire			ref_clk,
	input wire			reset_n,
	input wire			soft_powerdown_bit,
	// settings
	input wire [2:0]		rf_sel,
	input wire [5:0]		cf_sel,
	input wire [2:0]		gain_sel,
	input wire [3:0]		amb_cancel_sel,
	input wire [CNT_W-1:0]	prp_value,
	input wire [2:0]		rf_code_q,
	input wire [5:0]		cf_code_q,
	input wire [2:0]		gain_code_q,
	input wire [3:0]		amb_code_q,
	// timing and results
	input wire			active_q,
	input wire [3:0]		convert_phase_q,
	input wire [CNT_W-1:0]	timer_q,
	input wire [ADC_W-1:0]	res_emitter_b_q,
	input wire [ADC_W-1:0]	res_amb_b_q,
	input wire [ADC_W-1:0]	res_emitter_a_q,
	input wire [ADC_W-1:0]	res_amb_a_q,
	input wire [22:0]		res_diff_b_q,
	input wire [22:0]		res_diff_a_q,
	input wire			overrun_q,
	// stream
	input wire			out_valid,
	input wire			out_ready,
	input wire [2:0]		out_tag,
	input wire [22:0]		out_data
);
	reg [1:0] warm_q;
	// skip the edges where the pin sync and output stage still settle
	always @(posedge ref_clk) begin
		if (!reset_n)
			warm_q <= 2'h0;
		else if (warm_q != 2'h3)
			warm_q <= warm_q + 2'h1;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n || warm_q != 2'h3);
	AST_RF: assert property ($past(reset_n) |->
		rf_code_q == ($past(rf_sel) == 3'h7 ? $past(rf_code_q) : $past(rf_sel))) else $error("resistor code wrong");
	AST_CF: assert property ($past(reset_n) |-> cf_code_q == $past(cf_sel))
		else $error("capacitor enables wrong");
	AST_GAIN: assert property (gain_sel < 3'h5 |=> gain_code_q == $past(gain_sel))
		else $error("gain code wrong");
	AST_AMB: assert property (amb_cancel_sel > 4'hA |=> $stable(amb_code_q))
		else $error("ambient code taken out of range");
	AST_TIMER: assert property ($changed(timer_q) && active_q && $past(active_q) |->
		timer_q == $past(timer_q) + 16'h1 || (timer_q == 16'h0 && $past(timer_q) == $past(prp_value)))
		else $error("timer step wrong");
	AST_TIMER_MAX: assert property (active_q |-> timer_q <= prp_value)
		else $error("timer passed period");
	AST_TICK: assert property ($changed(timer_q) && active_q |=> $stable(timer_q) || !active_q)
		else $error("timer ticks too fast");
	AST_PD: assert property (soft_powerdown_bit |-> ##[1:2] !active_q && timer_q == 16'h0)
		else $error("power-down not idle");
	AST_ONECONV: assert property ($onehot0(convert_phase_q))
		else $error("two conversions at once");
	AST_DIFF_B: assert property ($changed(res_diff_b_q) |->
		res_diff_b_q == {res_emitter_b_q[ADC_W-1], res_emitter_b_q} - {res_amb_b_q[ADC_W-1], res_amb_b_q})
		else $error("difference b wrong");
	AST_DIFF_A: assert property ($changed(res_diff_a_q) |->
		res_diff_a_q == {res_emitter_a_q[ADC_W-1], res_emitter_a_q} - {res_amb_a_q[ADC_W-1], res_amb_a_q})
		else $error("difference a wrong");
	AST_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable({out_tag, out_data}))
		else $error("stream word dropped");
	AST_OVR: assert property (overrun_q |=> overrun_q)
		else $error("overrun flag lost");
	cover property (out_valid && out_ready && out_tag == 3'h5);
	cover property ($rose(overrun_q));
	cover property (soft_powerdown_bit && active_q);
endmodule // orr_readout_sva

bind orr_readout orr_readout_sva #(.CNT_W(CNT_W), .ADC_W(ADC_W)) u_sva (.ref_clk(ref_clk), .reset_n(reset_n),
	.soft_powerdown_bit(soft_powerdown_bit), .rf_sel(rf_sel), .cf_sel(cf_sel), .gain_sel(gain_sel),
	.amb_cancel_sel(amb_cancel_sel), .prp_value(prp_value), .rf_code_q(rf_code_q), .cf_code_q(cf_code_q),
	.gain_code_q(gain_code_q), .amb_code_q(amb_code_q), .active_q(active_q), .convert_phase_q(convert_phase_q),
	.timer_q(timer_q), .res_emitter_b_q(res_emitter_b_q), .res_amb_b_q(res_amb_b_q),
	.res_emitter_a_q(res_emitter_a_q), .res_amb_a_q(res_amb_a_q), .res_diff_b_q(res_diff_b_q),
	.res_diff_a_q(res_diff_a_q), .overrun_q(overrun_q), .out_valid(out_valid), .out_ready(out_ready),
	.out_tag(out_tag), .out_data(out_data));

// ### testbench/orr_host_sink.sv
/* host-side consumer of the result stream: ready always, every fourth cycle, or never.
   assumes mode only changes between scenarios. */
`timescale 1ns/1ps
module orr_host_sink (
	// clock
	input wire		ref_clk,
	// behaviour
	input wire [1:0]	mode,
	// handshake
	output reg		out_ready
);
	reg [1:0] cnt_q = 2'h0;
	initial out_ready = 1'b0;
	// falling edge keeps ready clear of the sampling edge
	always @(negedge ref_clk) begin
		cnt_q <= cnt_q + 2'h1;
		out_ready <= mode == 2'h0 || (mode == 2'h1 && cnt_q == 2'h0);
	end
endmodule // orr_host_sink

// ### testbench/orr_readout_tb.sv
/* self-checking bench: settings, result stream, power-down, overrun.
   assumes the sink model drives out_ready; fixed windows, period of 40 ticks. */
`timescale 1ns/1ps
`include "orr_defs.vh"
module orr_readout_tb;
	localparam [63:0] SS = 64'h0020_0016_000C_0002;
	localparam [63:0] SE = 64'h0024_001A_0010_0006; // short windows keep the run brief
	localparam [63:0] CS = 64'h0025_001B_0011_0007;
	localparam [63:0] CE = 64'h0026_001D_0013_0009;
	reg		ref_clk = 1'b0, reset_n = 1'b0, hard_powerdown_pin_n = 1'b1, soft_powerdown_bit = 1'b0;
	reg [2:0]	rf_sel = 3'h0, gain_sel = 3'h0, e_rf = 3'h0, e_gain = 3'h0;
	reg [5:0]	cf_sel = 6'h00;
	reg [3:0]	amb_cancel_sel = 4'h0, e_amb = 4'h0;
	reg [21:0]	adc_code = 22'h000000;
	reg [21:0]	code [0:3];
	reg [1:0]	mode = 2'h0;
	reg		track = 1'b1; // cleared while results are to be discarded
	reg [31:0]	seed = 32'h300A;
	reg [15:0]	prev_t = 16'h0000;
	reg [25:0]	exp_q [$];
	integer		c, i, k, n_mismatch = 0, comparisons = 0;
	wire [2:0]	rf_code_q, gain_code_q, out_tag;
	wire [5:0]	cf_code_q;
	wire [3:0]	amb_code_q, convert_phase_q, sample_phase_q;
	wire [15:0]	timer_q;
	wire [21:0]	res_emitter_b_q, res_amb_b_q, res_emitter_a_q, res_amb_a_q;
	wire [22:0]	res_diff_b_q, res_diff_a_q, out_data;
	wire		active_q, overrun_q, out_valid, out_ready;
	orr_readout dut (.ref_clk(ref_clk), .reset_n(reset_n), .hard_powerdown_pin_n(hard_powerdown_pin_n),
		.soft_powerdown_bit(soft_powerdown_bit), .rf_sel(rf_sel), .cf_sel(cf_sel), .gain_sel(gain_sel),
		.amb_cancel_sel(amb_cancel_sel), .prp_value(16'h0027), .samp_start(SS), .samp_end(SE),
		.conv_start(CS), .conv_end(CE), .adc_code(adc_code), .rf_code_q(rf_code_q), .cf_code_q(cf_code_q),
		.gain_code_q(gain_code_q), .amb_code_q(amb_code_q), .active_q(active_q), .sample_phase_q(sample_phase_q),
		.convert_phase_q(convert_phase_q), .timer_q(timer_q), .res_emitter_b_q(res_emitter_b_q),
		.res_amb_b_q(res_amb_b_q), .res_emitter_a_q(res_emitter_a_q), .res_amb_a_q(res_amb_a_q),
		.res_diff_b_q(res_diff_b_q), .res_diff_a_q(res_diff_a_q), .overrun_q(overrun_q), .out_valid(out_valid),
		.out_ready(out_ready), .out_tag(out_tag), .out_data(out_data));
	orr_host_sink u_sink (.ref_clk(ref_clk), .mode(mode), .out_ready(out_ready));
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function [22:0] sx(input [21:0] v);
		sx = {v[21], v};
	endfunction
	task chk_val(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
		comparisons = comparisons + 1;
		if (g !== e) begin
			n_mismatch = n_mismatch + 1;
			$display("mismatch %0s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task chk_word(input [25:0] e, input [25:0] g);
		comparisons = comparisons + 1;
		if (g !== e) begin
			n_mismatch = n_mismatch + 1;
			$display("mismatch stream expected %0h seen %0h", e, g);
		end
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task wait_timer(input [15:0] t);
		for (k = 0; k < 300 && timer_q !== t; k = k + 1)
			@(negedge ref_clk);
		chk_val("timer", t, timer_q);
		@(negedge ref_clk);
	endtask
	task wait_empty;
		for (k = 0; k < 400 && exp_q.size() != 0; k = k + 1)
			@(negedge ref_clk);
		chk_val("queue", 0, exp_q.size());
	endtask
	initial forever #50 ref_clk = ~ref_clk;
	initial begin
		#1000000;
		n_mismatch = n_mismatch + 1;
		print_verdict;
	end
	// adc model: a fresh code each time the timer reaches a convert end, noted for the monitor
	always @(negedge ref_clk) begin
		prev_t <= timer_q;
		for (c = 0; c < 4; c = c + 1)
			if (timer_q === CE[16*c +: 16] && prev_t !== timer_q) begin
				seed = lfsr(seed);
				code[c] = seed[21:0];
				adc_code = seed[21:0];
				if (track)
					exp_q.push_back({c[2:0], sx(seed[21:0])});
				if (track && c[0])
					exp_q.push_back({3'h4 + {2'h0, c[1]}, sx(code[c-1]) - sx(seed[21:0])});
			end
	end
	always @(posedge ref_clk) begin
		if (reset_n && out_valid && out_ready && track) begin
			if (exp_q.size() != 0) begin
				chk_word(exp_q.pop_front(), {out_tag, out_data});
			end else begin
				n_mismatch = n_mismatch + 1;
				$display("mismatch stream expected none seen %0h", {out_tag, out_data});
			end
		end
	end
	initial begin
		repeat (8) @(negedge ref_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		for (i = 0; i < 16; i = i + 1) begin
			seed = lfsr(seed);
			rf_sel = i[2:0];
			gain_sel = i[2:0];
			amb_cancel_sel = i[3:0];
			cf_sel = seed[5:0];
			if (i[2:0] != 3'h7)
				e_rf = i[2:0];
			if (i[2:0] < 3'h5)
				e_gain = i[2:0];
			if (i[3:0] < 4'hB)
				e_amb = i[3:0];
			@(negedge ref_clk);
			chk_val("rf", e_rf, rf_code_q);
			chk_val("cf", cf_sel, cf_code_q);
			chk_val("gain", e_gain, gain_code_q);
			chk_val("amb", e_amb, amb_code_q);
		end
		$display("test settings done");
		repeat (300) @(negedge ref_clk);
		mode = 2'h1;
		repeat (300) @(negedge ref_clk);
		mode = 2'h0;
		wait_timer(16'h0004);
		chk_val("sample", 4'h1, sample_phase_q);
		wait_timer(16'h0008);
		chk_val("convert", 4'h1, convert_phase_q);
		wait_timer(16'h0027);
		chk_val("res_eb", code[0], res_emitter_b_q);
		chk_val("res_ab", code[1], res_amb_b_q);
		chk_val("res_ea", code[2], res_emitter_a_q);
		chk_val("res_aa", code[3], res_amb_a_q);
		chk_val("diff_b", {9'h000, sx(code[0]) - sx(code[1])}, res_diff_b_q);
		chk_val("diff_a", {9'h000, sx(code[2]) - sx(code[3])}, res_diff_a_q);
		wait_empty;
		$display("test stream done");
		soft_powerdown_bit = 1'b1;
		repeat (10) @(negedge ref_clk);
		chk_val("active", 0, active_q);
		chk_val("timer", 0, timer_q);
		soft_powerdown_bit = 1'b0;
		repeat (200) @(negedge ref_clk);
		wait_timer(16'h0027);
		wait_empty;
		hard_powerdown_pin_n = 1'b0;
		repeat (10) @(negedge ref_clk);
		chk_val("active", 0, active_q);
		hard_powerdown_pin_n = 1'b1;
		reset_n = 1'b0;
		repeat (8) @(negedge ref_clk);
		reset_n = 1'b1;
		repeat (300) @(negedge ref_clk);
		wait_empty;
		$display("test power-down done");
		track = 1'b0;
		mode = 2'h2;
		repeat (300) @(negedge ref_clk);
		chk_val("overrun", 1, overrun_q);
		chk_val("valid", 1, out_valid);
		mode = 2'h0;
		for (k = 0; k < 60 && out_valid !== 1'b0; k = k + 1)
			@(negedge ref_clk);
		chk_val("drained", 0, out_valid);
		reset_n = 1'b0;
		repeat (8) @(negedge ref_clk);
		chk_val("overrun", 0, overrun_q);
		$display("test overrun done");
		print_verdict;
	end
endmodule // orr_readout_tb
